// file: logic/urf_consts.vh
// register map, field positions, reset values, sampling points and word lengths of the receiver.
// assumes inclusion by bare name from the design files only.
`ifndef URF_CONSTS_VH
`define URF_CONSTS_VH

`define URF_ADDR_CTRL    8'h00
`define URF_ADDR_BAUD    8'h04
`define URF_ADDR_STAT    8'h08
`define URF_ADDR_DATA    8'h0C
`define URF_ADDR_COUNT   8'h10

// control register fields
`define URF_CTRL_RXON    0
`define URF_CTRL_WL9     1
`define URF_CTRL_PON     2
`define URF_CTRL_PTYP_LO 3
`define URF_CTRL_PTYP_HI 4
`define URF_CTRL_RIE     5
`define URF_CTRL_TRG_LO  6
`define URF_CTRL_TRG_HI  7
`define URF_CTRL_MODE_LO 8
`define URF_CTRL_MODE_HI 10
`define URF_CTRL_RST     11'h000

`define URF_BAUD_RST     16'h0000

// status register fields
`define URF_ST_AVAIL     0
`define URF_ST_OVR       1
`define URF_ST_NOISE     2
`define URF_ST_FRAME     3
`define URF_ST_PAR       4
`define URF_ST_IDLE      5
`define URF_ST_NINTH     6

// fifo entry layout: {parity, framing, noise, word[8:0]}
`define URF_FE_NOISE     9
`define URF_FE_FRAME     10
`define URF_FE_PAR       11

// oversampling points inside one bit of sixteen ticks
`define URF_SMP_A        4'h7
`define URF_SMP_B        4'h8
`define URF_SMP_C        4'h9
`define URF_TICK_LAST    4'hF

`define URF_BITS_8       4'h8
`define URF_BITS_9       4'h9

`endif

// file: logic/urf_fifo.v
// four-entry receive fifo in flip-flops, word plus error flags per entry.
// assumes caller never pushes when full or pops when empty.
`timescale 1ns/1ps
`default_nettype none
module urf_fifo (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // write side
  input  wire        wr_i,
  input  wire [11:0] wdata_i,
  // read side
  input  wire        rd_i,
  output wire [11:0] rdata_o,
  // level
  output wire [2:0]  count_o,
  output wire        full_o,
  output wire        empty_o
);
  reg [11:0] mem_ff [0:3];
  reg [1:0]  wp_ff;
  reg [1:0]  rp_ff;
  reg [2:0]  cnt_ff;
  integer    i;

  assign rdata_o = mem_ff[rp_ff];
  assign count_o = cnt_ff;
  assign full_o  = (cnt_ff == 3'h4);
  assign empty_o = (cnt_ff == 3'h0);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_ff  <= 2'h0;
      rp_ff  <= 2'h0;
      cnt_ff <= 3'h0;
      for (i = 0; i < 4; i = i + 1) begin
        mem_ff[i] <= 12'h000;
      end
    end else begin
      if (wr_i) begin
        mem_ff[wp_ff] <= wdata_i;
        wp_ff         <= wp_ff + 2'h1;
      end
      if (rd_i) begin
        rp_ff <= rp_ff + 2'h1;
      end
      if (wr_i && !rd_i) begin
        cnt_ff <= cnt_ff + 3'h1;
      end else if (rd_i && !wr_i) begin
        cnt_ff <= cnt_ff - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/urf_rx_top.v
// serial receiver with four-entry fifo and apb register port.
// assumes the serial input is already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "urf_consts.vh"
module urf_rx_top (
  // clock and reset
  input  wire        SYS_CLK_I,
  input  wire        RST_I,
  // apb slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // serial line
  input  wire        SERIAL_LINE_PIN_I,
  output reg         RX_PIN_IS_INPUT_O,
  // interrupt request
  output reg         RX_IRQ_O
);
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_START = 5'b00010;
  localparam [4:0] ST_DATA  = 5'b00100;
  localparam [4:0] ST_STOP  = 5'b01000;
  localparam [4:0] ST_WAITH = 5'b10000;

  // software registers
  reg [10:0] ctrl_ff;
  reg [15:0] baud_ff;
  reg        armed_ff;
  reg        ovr_ff;
  // receive engine
  reg [4:0]  state_ff;
  reg [4:0]  nxt_state;
  reg [3:0]  tick_cnt_ff;
  reg [3:0]  bit_cnt_ff;
  reg [8:0]  rx_shift_register_ff;
  reg [1:0]  smp_ff;
  reg        noise_ff;
  reg        idle_ff;

  wire       receiver_on         = ctrl_ff[`URF_CTRL_RXON];
  wire       word_length_select  = ctrl_ff[`URF_CTRL_WL9];
  wire       parity_on           = ctrl_ff[`URF_CTRL_PON];
  wire [1:0] parity_type_select  = ctrl_ff[`URF_CTRL_PTYP_HI:`URF_CTRL_PTYP_LO];
  wire       rx_interrupt_enable = ctrl_ff[`URF_CTRL_RIE];
  wire [1:0] trig_sel            = ctrl_ff[`URF_CTRL_TRG_HI:`URF_CTRL_TRG_LO];
  wire [2:0] baud_mode_select    = ctrl_ff[`URF_CTRL_MODE_HI:`URF_CTRL_MODE_LO];

  wire        tick;
  wire        fifo_full;
  wire        fifo_empty;
  wire [2:0]  rx_fill_count;
  wire [11:0] head;

  // apb decode
  wire       setup   = PSEL_I && !PENABLE_I;
  wire       access  = PSEL_I && PENABLE_I && PREADY_O;
  wire       wr_acc  = access && PWRITE_I;
  wire       rd_acc  = access && !PWRITE_I;
  wire       hit_stat = (PADDR_I == `URF_ADDR_STAT);
  wire       hit_data = (PADDR_I == `URF_ADDR_DATA);
  wire       mapped  = (PADDR_I == `URF_ADDR_CTRL) || (PADDR_I == `URF_ADDR_BAUD) ||
                       hit_stat || hit_data || (PADDR_I == `URF_ADDR_COUNT);
  wire       clear_seq = rd_acc && hit_data && armed_ff;

  // majority of three samples and disagreement among them
  wire       sample_c = (tick_cnt_ff == `URF_SMP_C);
  wire       vote     = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & SERIAL_LINE_PIN_I) |
                        (smp_ff[1] & SERIAL_LINE_PIN_I);
  wire       disagree = !((smp_ff[0] == smp_ff[1]) && (smp_ff[1] == SERIAL_LINE_PIN_I));
  wire       bit_end  = tick && (tick_cnt_ff == `URF_TICK_LAST);
  wire       decide   = tick && sample_c;
  wire [3:0] nbits    = word_length_select ? `URF_BITS_9 : `URF_BITS_8;

  // word alignment: 8-bit words sit in the upper shift bits
  wire [8:0] word = word_length_select ? rx_shift_register_ff :
                    {1'b0, rx_shift_register_ff[8:1]};
  // parity bit is the top received bit, so it is already inside the xor
  wire       par_sum = word_length_select ? (^word) : (^word[7:0]);
  // even type wants even ones incl. parity, odd wants odd; mark/space unchecked
  wire       par_err = parity_on && !parity_type_select[1] &&
                       (par_sum ^ parity_type_select[0]);
  wire       stop_done = (state_ff == ST_STOP) && decide;
  wire       push      = stop_done && !fifo_full;
  wire       overrun   = stop_done && fifo_full;
  wire       frame_err = !vote;
  wire [11:0] entry    = {par_err, frame_err, noise_ff | disagree, word};

  urf_tick_gen u_tick (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .run_i     (receiver_on),
    .divisor_i (baud_ff),
    .mode_i    (baud_mode_select),
    .tick_o    (tick)
  );

  urf_fifo u_fifo (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .wr_i    (push),
    .wdata_i (entry),
    .rd_i    (clear_seq && !fifo_empty),
    .rdata_o (head),
    .count_o (rx_fill_count),
    .full_o  (fifo_full),
    .empty_o (fifo_empty)
  );

  // next state of the receive engine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (tick && !SERIAL_LINE_PIN_I) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (decide && vote) begin
          nxt_state = ST_IDLE;
        end else if (bit_end) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (bit_end && (bit_cnt_ff == nbits - 4'h1)) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // a low stop means break or bad frame: hold off until line is high
        if (decide) begin
          nxt_state = vote ? ST_IDLE : ST_WAITH;
        end
      end
      ST_WAITH: begin
        if (decide && vote) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // receive engine registers
  always @(posedge SYS_CLK_I) begin
    if (RST_I || !receiver_on) begin
      state_ff             <= ST_IDLE;
      tick_cnt_ff          <= 4'h0;
      bit_cnt_ff           <= 4'h0;
      rx_shift_register_ff <= 9'h000;
      smp_ff               <= 2'h0;
      noise_ff             <= 1'b0;
      idle_ff              <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (tick) begin
        tick_cnt_ff <= tick_cnt_ff + 4'h1;
        if (tick_cnt_ff == `URF_SMP_A) begin
          smp_ff[0] <= SERIAL_LINE_PIN_I;
        end
        if (tick_cnt_ff == `URF_SMP_B) begin
          smp_ff[1] <= SERIAL_LINE_PIN_I;
        end
      end
      if (state_ff == ST_IDLE) begin
        // start edge seen at this tick counts as tick zero of the start bit
        tick_cnt_ff <= 4'h1;
        bit_cnt_ff  <= 4'h0;
        noise_ff    <= 1'b0;
        if (nxt_state == ST_START) begin
          idle_ff <= 1'b0;
        end
      end
      if (decide && (state_ff != ST_IDLE) && disagree) begin
        noise_ff <= 1'b1;
      end
      if ((state_ff == ST_DATA) && decide) begin
        rx_shift_register_ff <= {vote, rx_shift_register_ff[8:1]};
      end
      if ((state_ff == ST_DATA) && bit_end) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (stop_done) begin
        idle_ff <= 1'b1;
      end
      if ((state_ff == ST_WAITH) && bit_end) begin
        tick_cnt_ff <= 4'h0;
      end
    end
  end

  // software registers; shift register has no address of its own
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ctrl_ff  <= `URF_CTRL_RST;
      baud_ff  <= `URF_BAUD_RST;
      armed_ff <= 1'b0;
      ovr_ff   <= 1'b0;
    end else begin
      if (wr_acc && (PADDR_I == `URF_ADDR_CTRL)) begin
        ctrl_ff <= PWDATA_I[10:0];
      end
      if (wr_acc && (PADDR_I == `URF_ADDR_BAUD)) begin
        baud_ff <= PWDATA_I[15:0];
      end
      if (access && hit_stat) begin
        armed_ff <= 1'b1;
      end else if (rd_acc && hit_data) begin
        armed_ff <= 1'b0;
      end
      // new overrun in the clearing cycle wins
      if (overrun) begin
        ovr_ff <= 1'b1;
      end else if (clear_seq) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  // apb answer: data latched in setup, ready in first access cycle
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup && !mapped;
      if (setup) begin
        PRDATA_O <= 32'h0000_0000;
        if (!PWRITE_I) begin
          case (PADDR_I)
            `URF_ADDR_CTRL: begin
              PRDATA_O <= {21'h00_0000, ctrl_ff};
            end
            `URF_ADDR_BAUD: begin
              PRDATA_O <= {16'h0000, baud_ff};
            end
            `URF_ADDR_STAT: begin
              PRDATA_O <= {25'h000_0000,
                           head[8] & !fifo_empty,
                           idle_ff,
                           head[`URF_FE_PAR] & !fifo_empty,
                           head[`URF_FE_FRAME] & !fifo_empty,
                           head[`URF_FE_NOISE] & !fifo_empty,
                           ovr_ff,
                           !fifo_empty};
            end
            `URF_ADDR_DATA: begin
              PRDATA_O <= {24'h00_0000, head[7:0] & {8{!fifo_empty}}};
            end
            `URF_ADDR_COUNT: begin
              PRDATA_O <= {29'h0000_0000, rx_fill_count};
            end
            default: begin
              PRDATA_O <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  // interrupt and pin role
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RX_IRQ_O          <= 1'b0;
      RX_PIN_IS_INPUT_O <= 1'b0;
    end else begin
      RX_PIN_IS_INPUT_O <= receiver_on;
      // level request; noise alone never adds a source
      RX_IRQ_O <= rx_interrupt_enable &&
                  ((rx_fill_count >= ({1'b0, trig_sel} + 3'h1)) || ovr_ff);
    end
  end
endmodule
`default_nettype wire

// file: logic/urf_tick_gen.v
// sixteen-times-baud tick generator: one-cycle enable pulse.
// assumes divisor and mode are stable while the receiver is on.
`timescale 1ns/1ps
`default_nettype none
module urf_tick_gen (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // setup
  input  wire        run_i,
  input  wire [15:0] divisor_i,
  input  wire [2:0]  mode_i,
  // tick
  output reg         tick_o
);
  reg [6:0]  pre_ff;
  reg [15:0] div_ff;
  wire       pre_done;

  // mode picks a power-of-two prescale ahead of the divisor
  assign pre_done = (pre_ff == ((7'h01 << mode_i) - 7'h01));

  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pre_ff <= 7'h00;
      div_ff <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (pre_done) begin
        pre_ff <= 7'h00;
        if (div_ff >= divisor_i) begin
          div_ff <= 16'h0000;
          tick_o <= 1'b1;
        end else begin
          div_ff <= div_ff + 16'h0001;
        end
      end else begin
        pre_ff <= pre_ff + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/urf_line_model.sv
// remote serial transmitter: drives the line one frame at a time.
// assumes a tick every clock, so one bit lasts sixteen clocks; idle high.
`timescale 1ns/1ps
`default_nettype none
module urf_line_model (
  // clock
  input  wire logic SYS_CLK_I,
  // serial line
  output var  logic line_o
);
  localparam int BIT_CLKS = 16;
  initial line_o = 1'b1;
  task automatic hold(input logic v, input int n);
    line_o <= v;
    repeat (n) @(posedge SYS_CLK_I);
  endtask
  // noisy: one clock of wrong level inside bit 0, majority still right
  task automatic send(input logic [8:0] w, input int nbits, input logic noisy);
    int i;
    hold(1'b0, BIT_CLKS);
    for (i = 0; i < nbits; i++) begin
      if (noisy && i == 0) begin
        hold(w[0], 8);
        hold(!w[0], 1);
        hold(w[0], 7);
      end else
        hold(w[i], BIT_CLKS);
    end
    hold(1'b1, BIT_CLKS + 4);
  endtask
  task automatic brk(input int nbits);
    hold(1'b0, nbits * BIT_CLKS);
    hold(1'b1, BIT_CLKS + 4);
  endtask
endmodule
`default_nettype wire

// file: test/urf_rx_checker.sv
// assertion checker for the receiver top: apb handshake, errors, irq, pin use.
// assumes it is bound onto urf_rx_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module urf_rx_checker (
  // clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RST_I,
  // apb
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // serial line and irq
  input wire logic        SERIAL_LINE_PIN_I,
  input wire logic        RX_PIN_IS_INPUT_O,
  input wire logic        RX_IRQ_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  logic mapped;
  assign mapped = PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  sequence s_done; PSEL_I && PENABLE_I && PREADY_O; endsequence
  sequence s_on_wr; s_done ##0 (PWRITE_I && PADDR_I == 8'h00 && PWDATA_I[0]); endsequence
  property p_ready; s_setup |=> PREADY_O; endproperty
  property p_single; PREADY_O |=> !PREADY_O; endproperty
  property p_in_access; PREADY_O |-> PSEL_I && PENABLE_I; endproperty
  property p_unmapped; s_setup ##0 !mapped |=> PSLVERR_O; endproperty
  property p_mapped; s_setup ##0 mapped |=> !PSLVERR_O; endproperty
  property p_err_zero; PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0000_0000; endproperty
  property p_reset; $fell(RST_I) |-> !RX_IRQ_O && !RX_PIN_IS_INPUT_O && !PREADY_O; endproperty
  property p_pin; s_on_wr |-> ##[1:2] RX_PIN_IS_INPUT_O; endproperty
  // a level: only a register access can take it away
  property p_irq_hold; RX_IRQ_O && !PSEL_I && !$past(PSEL_I) && !$past(PSEL_I, 2) |=> RX_IRQ_O; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_single: assert property (p_single) else $error("ready longer than one cycle");
  a_in_access: assert property (p_in_access) else $error("ready outside access");
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
  a_mapped: assert property (p_mapped) else $error("error on mapped address");
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  a_pin: assert property (p_pin) else $error("line not taken as input");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without access");
endmodule
bind urf_rx_top urf_rx_checker u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SERIAL_LINE_PIN_I(SERIAL_LINE_PIN_I),
  .RX_PIN_IS_INPUT_O(RX_PIN_IS_INPUT_O), .RX_IRQ_O(RX_IRQ_O)
);
`default_nettype wire

// file: test/urf_rx_top_tb.sv
// self-checking bench for the receiver: apb master tasks and scenarios.
// assumes the line model stands in for the remote transmitter.
`timescale 1ns/1ps
`default_nettype none
module urf_rx_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        line;
  logic        pin_in;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  urf_rx_top dut (
    .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SERIAL_LINE_PIN_I(line), .RX_PIN_IS_INPUT_O(pin_in), .RX_IRQ_O(irq)
  );
  urf_line_model tx (.SYS_CLK_I(clk), .line_o(line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic cfg(input logic [10:0] c);
    int k;
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, {21'h0, c});
    for (k = 0; k < 8 && pin_in !== c[0]; k++) @(posedge clk);
    chk(pin_in, c[0]);
  endtask
  task automatic t_reset;
    chk(pin_in, 1'b0);
    rd_chk(8'h08, 8'h20);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h14, 8'h00);
    chk(err, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_fifo;
    logic [7:0] w [5] = '{8'h01, 8'h80, 8'h5A, 8'hC3, 8'hFF};
    int i;
    cfg(11'h0E1);
    for (i = 0; i < 5; i++) begin
      tx.send({1'b0, w[i]}, 8, 1'b0);
      if (i < 4) chk(irq, i == 3);
    end
    rd_chk(8'h08, 8'h23);
    rd_chk(8'h10, 8'h04);
    chk(irq, 1'b1);
    rd_chk(8'h0C, 8'h01);
    rd_chk(8'h0C, 8'h80);
    rd_chk(8'h10, 8'h03);
    for (i = 1; i < 4; i++) begin
      rd_chk(8'h08, 8'h21);
      rd_chk(8'h0C, w[i]);
    end
    rd_chk(8'h08, 8'h20);
    chk(irq, 1'b0);
    $display("test fifo done");
  endtask
  task automatic t_nine;
    cfg(11'h003);
    tx.send(9'h1A5, 9, 1'b0);
    rd_chk(8'h08, 8'h61);
    rd_chk(8'h0C, 8'hA5);
    $display("test nine done");
  endtask
  task automatic t_noise;
    cfg(11'h0E1);
    tx.send(9'h055, 8, 1'b1);
    rd_chk(8'h08, 8'h25);
    chk(irq, 1'b0);
    rd_chk(8'h0C, 8'h55);
    rd_chk(8'h08, 8'h20);
    $display("test noise done");
  endtask
  task automatic t_parity;
    cfg(11'h005);
    tx.send(9'h003, 8, 1'b0);
    tx.send(9'h083, 8, 1'b0);
    rd_chk(8'h08, 8'h21);
    rd_chk(8'h0C, 8'h03);
    rd_chk(8'h08, 8'h31);
    rd_chk(8'h0C, 8'h83);
    $display("test parity done");
  endtask
  task automatic t_break;
    cfg(11'h001);
    tx.brk(20);
    rd_chk(8'h10, 8'h01);
    rd_chk(8'h08, 8'h29);
    rd_chk(8'h0C, 8'h00);
    $display("test break done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fifo();
    t_nine();
    t_noise();
    t_parity();
    t_break();
    complete_run();
  end
endmodule
`default_nettype wire
